// ### verilog/e1_rx_out_pkg.sv
// Package for the eight-channel E1 receive output block: timing constants,
// register map, control field positions and the per-channel carriers.
// Assumes a single 100 MHz system clock and an APB register bus.
package e1_rx_out_pkg;

  // Clock and line rates, and the phase step of the clock-recovery NCO
  localparam longint CLOCK_HZ      = 100_000_000;
  localparam longint LINE_RATE_HZ  = 2_048_000;
  localparam int     PHASE_WIDTH   = 32;
  localparam logic [PHASE_WIDTH-1:0] PHASE_STEP =
    PHASE_WIDTH'((LINE_RATE_HZ << PHASE_WIDTH) / CLOCK_HZ);
  // Phase loaded on the first pulse of a bit: pulse sits early in the bit
  localparam logic [PHASE_WIDTH-1:0] PHASE_ALIGN = 32'h4000_0000;

  localparam int NUM_CHANNELS = 8;
  localparam int COUNT_WIDTH  = 16;
  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = 16'hFFFF;
  // Zeros in a row that make an excessive-zeros violation
  localparam logic [2:0] EXCESS_ZEROS = 3'h4;
  localparam logic [2:0] HDB3_RUN     = 3'h3;

  // APB register map (byte addresses)
  localparam int ADDR_WIDTH = 8;
  localparam logic [ADDR_WIDTH-1:0] REG_CONTROL     = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] REG_RX_ENABLE   = 8'h04;
  localparam logic [ADDR_WIDTH-1:0] REG_COUNT_RESET = 8'h08;
  localparam logic [ADDR_WIDTH-1:0] REG_STATUS      = 8'h0C;
  localparam logic [ADDR_WIDTH-1:0] REG_IRQ_STATUS  = 8'h10;
  localparam logic [ADDR_WIDTH-1:0] REG_IRQ_MASK    = 8'h14;
  localparam logic [ADDR_WIDTH-1:0] REG_COUNT_BASE  = 8'h20;

  // Control register fields
  localparam int CTRL_WIDTH       = 4;
  localparam int CTRL_EDGE_BIT    = 0;
  localparam int CTRL_SINGLE_BIT  = 1;
  localparam int CTRL_OVERFLOW_BIT = 2;
  localparam int CTRL_HOST_BIT    = 3;
  localparam logic [CTRL_WIDTH-1:0]   CTRL_RESET      = 4'h0;
  localparam logic [NUM_CHANNELS-1:0] RX_ENABLE_RESET = 8'hFF;
  // Edge select value that updates data on the rising clock edge
  localparam logic EDGE_RISING = 1'b0;

  // Interrupt layout: loss events low byte, counter saturation high byte
  localparam int IRQ_WIDTH    = 2 * NUM_CHANNELS;
  localparam int IRQ_SAT_BASE = NUM_CHANNELS;

  // Sliced line input of one channel
  typedef struct packed {
    logic lineInputPositive;
    logic lineInputNegative;
    logic lineHighZ;
    logic lossCondition;
  } line_in_t;

  // Receive output of one channel
  typedef struct packed {
    logic recoveredClock;
    logic positiveRailDataOut;
    logic negativeRailDataOut;
    logic lossOfSignalFlag;
  } rx_out_t;

endpackage

// ### verilog/e1_receive_output_interface.sv
// Receive output side of an eight-channel E1 line interface: clock
// recovery, rail/NRZ data, violation indicator, loss flag, APB registers.
// Assumes sliced line pulses and loss detection arrive synchronous to clock.
//
// Summary of operation
// RQ1: Receiver-on input switches all receivers together; in host mode the code ignores it and uses per-channel enables instead.
// RQ2: Receivers default on; input treated as pulled high.
// RQ3: Loss flag rises, held one recovered cycle minimum; the code holds it only until the next recovered rising edge.
// RQ4: Loss flag falls only after the condition clears.
// RQ5: Receive clock recovered from incoming line pulses.
// RQ6: Without signal, clock free-runs from master clock.
// RQ7: Data updates on the selected receive clock edge.
// RQ8: One global edge select for all channels.
// RQ9: Positive output carries pulses or NRZ data.
// RQ10: Single rail: negative output flags violations.
// RQ11: Overflow select: indicator follows saturated counter.
// RQ12: Eight independent channel instances of this logic.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module e1_receive_output_interface
  import e1_rx_out_pkg::*;
(
  input  wire logic                              clock,
  input  wire logic                              reset_n,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [ADDR_WIDTH-1:0]             paddr,
  input  wire logic [31:0]                       pwdata,
  output var  logic [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              receiverOnInput,
  input  wire line_in_t [NUM_CHANNELS-1:0]       lineIn,
  output var  rx_out_t  [NUM_CHANNELS-1:0]       rxOut,
  output logic                                   interrupt
);

  // True when an address hits one of the per-channel counter words
  function automatic logic isCountAddr(input logic [ADDR_WIDTH-1:0] a);
    isCountAddr = (a >= REG_COUNT_BASE) &&
                  (a < REG_COUNT_BASE + ADDR_WIDTH'(4 * NUM_CHANNELS)) &&
                  (a[1:0] == 2'h0);
  endfunction

  logic [CTRL_WIDTH-1:0]   control;
  logic [NUM_CHANNELS-1:0] rxEnable;
  logic [IRQ_WIDTH-1:0]    irqStatus;
  logic [IRQ_WIDTH-1:0]    irqMask;
  logic [NUM_CHANNELS-1:0] countReset;
  logic                    receiverOnSeen;
  logic [COUNT_WIDTH-1:0]  violCount [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0] lossFlags;
  logic [NUM_CHANNELS-1:0] lossRise;
  logic [NUM_CHANNELS-1:0] saturated;
  logic [NUM_CHANNELS-1:0] satRise;
  logic [NUM_CHANNELS-1:0] receiverOn;

  // Global settings shared by every channel
  wire logic edgeSelect     = control[CTRL_EDGE_BIT];     // [RQ8]
  wire logic singleRail     = control[CTRL_SINGLE_BIT];
  wire logic overflowSelect = control[CTRL_OVERFLOW_BIT];
  wire logic hostMode       = control[CTRL_HOST_BIT];

  // APB decode; zero wait states, so pready is always high
  wire logic accessPhase = psel & penable;
  wire logic setupPhase  = psel & ~penable;
  wire logic writeAccess = accessPhase & pwrite;
  wire logic hitControl  = (paddr == REG_CONTROL);
  wire logic hitEnable   = (paddr == REG_RX_ENABLE);
  wire logic hitCountRst = (paddr == REG_COUNT_RESET);
  wire logic hitStatus   = (paddr == REG_STATUS);
  wire logic hitIrqStat  = (paddr == REG_IRQ_STATUS);
  wire logic hitIrqMask  = (paddr == REG_IRQ_MASK);
  wire logic hitCount    = isCountAddr(paddr);
  wire logic addrHit     = hitControl | hitEnable | hitCountRst |
                           hitStatus | hitIrqStat | hitIrqMask | hitCount;
  wire logic [2:0] countIndex = 3'((paddr - REG_COUNT_BASE) >> 2);

  assign pready  = 1'b1;
  assign pslverr = accessPhase & ~addrHit;

  // Read data selection for the word captured in the setup phase
  logic [31:0] readWord;
  always_comb begin
    readWord = 32'h0000_0000;
    if (hitControl) begin
      readWord = 32'(control);
    end else if (hitEnable) begin
      readWord = 32'(rxEnable);
    end else if (hitStatus) begin
      readWord = 32'({saturated, lossFlags});
    end else if (hitIrqStat) begin
      readWord = 32'(irqStatus);
    end else if (hitIrqMask) begin
      readWord = 32'(irqMask);
    end else if (hitCount) begin
      readWord = 32'(violCount[countIndex]);
    end
  end

  // Read data is registered at setup, so it is stable through the access
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h0000_0000 : readWord;
    end
  end

  // Control, enable and interrupt mask registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      control  <= CTRL_RESET;
      rxEnable <= RX_ENABLE_RESET;
      irqMask  <= '0;
    end else if (writeAccess) begin
      if (hitControl) control <= pwdata[CTRL_WIDTH-1:0];
      if (hitEnable)  rxEnable <= pwdata[NUM_CHANNELS-1:0];
      if (hitIrqMask) irqMask <= pwdata[IRQ_WIDTH-1:0];
    end
  end

  // Counter reset is a one-cycle pulse per channel, write one to fire
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      countReset <= '0;
    end else begin
      countReset <= (writeAccess & hitCountRst) ?
                    pwdata[NUM_CHANNELS-1:0] : '0;
    end
  end

  // Sticky events; a new event wins over a write-one clear
  wire logic [IRQ_WIDTH-1:0] irqEvents = {satRise, lossRise};
  wire logic [IRQ_WIDTH-1:0] irqClear  =
    (writeAccess & hitIrqStat) ? pwdata[IRQ_WIDTH-1:0] : '0;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus <= '0;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqEvents;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      interrupt <= 1'b0;
    end else begin
      interrupt <= |(irqStatus & irqMask);
    end
  end

  // Pad pull-up is modelled by a reset value of one: receivers stay on
  // until the pin is actually seen low after reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      receiverOnSeen <= 1'b1;                                  // [RQ2]
    end else begin
      receiverOnSeen <= receiverOnInput;
    end
  end

  // Hardware mode: one pin for all; host mode: per-channel enables
  assign receiverOn = hostMode ? rxEnable :
                      {NUM_CHANNELS{receiverOnSeen}};          // [RQ1]

  // One independent receive channel per line
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : gChannel // [RQ12]
    logic [PHASE_WIDTH-1:0] phase;
    logic                   seenPos;
    logic                   seenNeg;
    logic                   lastWasPos;
    logic [2:0]             zeroRun;
    logic                   bitPos;
    logic                   bitNeg;
    logic                   bitViol;
    logic                   lossHeld;
    logic                   lossMinDone;
    logic                   satSeen;
    logic [COUNT_WIDTH-1:0] count;

    wire line_in_t lin = lineIn[ch];
    wire logic on      = receiverOn[ch];
    // Pulses only count while a real signal is present
    wire logic present = on & ~lin.lineHighZ & ~lin.lossCondition;
    wire logic pulsePos = present & lin.lineInputPositive;
    wire logic pulseNeg = present & lin.lineInputNegative;
    wire logic firstPulse = (pulsePos | pulseNeg) & ~seenPos & ~seenNeg;

    // NCO free-runs off the master clock and is pulled in by line pulses
    wire logic [PHASE_WIDTH-1:0] stepped = phase + PHASE_STEP;  // [RQ6]
    wire logic [PHASE_WIDTH-1:0] next_phase =
      firstPulse ? PHASE_ALIGN : stepped;                       // [RQ5]
    wire logic riseEvt = ~phase[PHASE_WIDTH-1] & next_phase[PHASE_WIDTH-1];
    wire logic fallEvt = phase[PHASE_WIDTH-1] & ~next_phase[PHASE_WIDTH-1];
    wire logic updateEvt =
      (edgeSelect == EDGE_RISING) ? riseEvt : fallEvt;          // [RQ7]

    // Symbol of the bit that closes at this falling edge
    wire logic symPos = seenPos | pulsePos;
    wire logic symNeg = seenNeg | pulseNeg;
    wire logic symMark = symPos | symNeg;
    // Same polarity twice is legal only as a substitution after 3 zeros
    wire logic bipolarViol = symMark & (symPos == lastWasPos) &
                             (zeroRun != HDB3_RUN);
    wire logic zerosViol = ~symMark & (zeroRun == EXCESS_ZEROS - 3'h1);
    wire logic isSat = (count == COUNT_MAX);

    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        phase <= '0;
      end else begin
        phase <= next_phase;
      end
    end

    // Collect pulses during one bit period
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        seenPos <= 1'b0;
        seenNeg <= 1'b0;
      end else if (fallEvt) begin
        seenPos <= 1'b0;
        seenNeg <= 1'b0;
      end else begin
        seenPos <= seenPos | pulsePos;
        seenNeg <= seenNeg | pulseNeg;
      end
    end

    // Close the bit: polarity history, zero run, violation
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        lastWasPos <= 1'b0;
        zeroRun    <= 3'h0;
        bitPos     <= 1'b0;
        bitNeg     <= 1'b0;
        bitViol    <= 1'b0;
      end else if (fallEvt) begin
        bitPos  <= symPos;
        bitNeg  <= symNeg;
        bitViol <= present & (bipolarViol | zerosViol);
        if (symMark) begin
          lastWasPos <= symPos;
          zeroRun    <= 3'h0;
        end else if (zeroRun != EXCESS_ZEROS) begin
          zeroRun <= zeroRun + 3'h1;
        end
      end
    end

    // Saturating violation counter, cleared from software
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        count <= '0;
      end else if (countReset[ch]) begin
        count <= '0;
      end else if (fallEvt && present && (bipolarViol || zerosViol) &&
                   !isSat) begin
        count <= count + COUNT_WIDTH'(1);
      end
    end

    // Outputs move only on the chosen edge, so each value lasts a full
    // recovered cycle; receiver off forces the data lines low
    wire logic indicator = overflowSelect ? isSat : bitViol;    // [RQ11]
    wire logic next_pos = singleRail ? (bitPos | bitNeg) : bitPos; // [RQ9]
    wire logic next_neg = singleRail ? indicator : bitNeg;      // [RQ10]
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        rxOut[ch].positiveRailDataOut <= 1'b0;
        rxOut[ch].negativeRailDataOut <= 1'b0;
      end else if (!on) begin
        rxOut[ch].positiveRailDataOut <= 1'b0;                  // [RQ1]
        rxOut[ch].negativeRailDataOut <= 1'b0;
      end else if (updateEvt) begin
        rxOut[ch].positiveRailDataOut <= next_pos;              // [RQ7]
        rxOut[ch].negativeRailDataOut <= next_neg;              // [RQ10]
      end
    end

    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        rxOut[ch].recoveredClock <= 1'b0;
      end else begin
        rxOut[ch].recoveredClock <= next_phase[PHASE_WIDTH-1];  // [RQ5]
      end
    end

    // Loss flag: set at once, released only after the condition is gone
    // and one recovered rising edge has passed
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        lossHeld    <= 1'b0;
        lossMinDone <= 1'b0;
      end else if (on && lin.lossCondition && !lossHeld) begin
        lossHeld    <= 1'b1;                                    // [RQ3]
        lossMinDone <= 1'b0;
      end else if (lossHeld) begin
        if (riseEvt) lossMinDone <= 1'b1;                       // [RQ3]
        if (lossMinDone && !lin.lossCondition) lossHeld <= 1'b0; // [RQ4]
      end
    end

    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        rxOut[ch].lossOfSignalFlag <= 1'b0;
        satSeen <= 1'b0;
      end else begin
        rxOut[ch].lossOfSignalFlag <= lossHeld;
        satSeen <= isSat;
      end
    end

    assign violCount[ch] = count;
    assign lossFlags[ch] = lossHeld;
    assign lossRise[ch]  = lossHeld & ~rxOut[ch].lossOfSignalFlag;
    assign saturated[ch] = isSat;
    assign satRise[ch]   = isSat & ~satSeen;
  end

endmodule

`default_nettype wire

// ### tb/e1_rx_out_props.sv
// Checker for the E1 receive output block, bound to its top module.
// Assumes control changes only through APB writes seen at the ports.
`timescale 1ns/10ps
`default_nettype none
module e1_rx_out_props
  import e1_rx_out_pkg::*;
(
  input wire logic                        clock,
  input wire logic                        reset_n,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [ADDR_WIDTH-1:0]       paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        receiverOnInput,
  input wire line_in_t [NUM_CHANNELS-1:0] lineIn,
  input wire rx_out_t  [NUM_CHANNELS-1:0] rxOut,
  input wire logic                        interrupt
);
  typedef logic [NUM_CHANNELS-1:0] chan_t;
  chan_t      clkV, posV, negV, flagV, lossV, edgeV;
  chan_t      prevClk, prevPos, prevNeg, prevFlag, prevEdge, edgeSeen;
  logic       ctrlWr, edgeSel, hostMode;
  logic [6:0] quiet;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Per-channel views; every recovered clock must keep toggling
  for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_ch
    assign clkV[i]  = rxOut[i].recoveredClock;
    assign posV[i]  = rxOut[i].positiveRailDataOut;
    assign negV[i]  = rxOut[i].negativeRailDataOut;
    assign flagV[i] = rxOut[i].lossOfSignalFlag;
    assign lossV[i] = lineIn[i].lossCondition;
    clock_run_a: assert property (##[1:45] clkV[i] != $past(clkV[i]))
      else $error("recovered clock stopped");
  end
  assign ctrlWr = psel && penable && pwrite && paddr == REG_CONTROL;
  assign edgeV  = edgeSel ? (prevClk & ~clkV) : (~prevClk & clkV);
  // Control mirror; quiet waits out settings changes before edge checks
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {edgeSel, hostMode, quiet} <= '0;
      {prevClk, prevPos, prevNeg, prevFlag, prevEdge, edgeSeen} <= '0;
    end else begin
      if (ctrlWr) begin
        edgeSel  <= pwdata[CTRL_EDGE_BIT];
        hostMode <= pwdata[CTRL_HOST_BIT];
      end
      quiet <= (ctrlWr || !receiverOnInput) ? 7'h0 : quiet + 7'(quiet != 7'h7F);
      {prevClk, prevPos, prevNeg, prevFlag} <= {clkV, posV, negV, flagV};
      prevEdge <= edgeV;
      edgeSeen <= flagV & (edgeSeen | (~prevClk & clkV));
    end
  end
  rx_off_mute_a: assert property (
    (!hostMode && !receiverOnInput)[*3] |-> posV == '0 && negV == '0)
    else $error("data not muted with receivers off");
  loss_raise_a: assert property ((!hostMode && receiverOnInput)[*5] |->
    (lossV & $past(lossV) & $past(lossV, 2) & $past(lossV, 3) & ~flagV) == '0)
    else $error("loss flag not raised");
  loss_min_a: assert property ((prevFlag & ~flagV & ~edgeSeen) == '0)
    else $error("loss flag fell before a recovered clock cycle");
  loss_hold_a: assert property (|(flagV & lossV) |=>
    (flagV & $past(flagV & lossV)) == $past(flagV & lossV))
    else $error("loss flag fell while condition present");
  edge_align_a: assert property (quiet == 7'h7F |-> (((posV ^ prevPos) |
    (negV ^ prevNeg)) & ~(edgeV | prevEdge)) == '0)
    else $error("data moved off the selected clock edge");
  ready_wait_a: assert property (psel |-> pready)
    else $error("pready low during a transfer");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  unmapped_read_a: assert property (psel && penable && !pwrite && pslverr
    |-> prdata == 32'h0)
    else $error("refused read returned data");
endmodule
bind e1_receive_output_interface e1_rx_out_props i_props (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .receiverOnInput(receiverOnInput),
  .lineIn(lineIn), .rxOut(rxOut), .interrupt(interrupt)
);
`default_nettype wire

// ### tb/e1_framer_model.sv
// Downstream framer model: counts clocks and marks per channel.
// Assumes edgeSelect mirrors the block's edge select setting.
`timescale 1ns/10ps
`default_nettype none
module e1_framer_model
  import e1_rx_out_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       reset_n,
  input wire logic                       clear,
  input wire logic                       edgeSelect,
  input wire rx_out_t [NUM_CHANNELS-1:0] rxOut
);
  logic [NUM_CHANNELS-1:0] prevClk;
  logic [7:0]              posCount [NUM_CHANNELS];
  logic [7:0]              negCount [NUM_CHANNELS];
  logic [7:0]              clkCount [NUM_CHANNELS];
  // Sample mid-bit, on the edge opposite the update edge, for margin
  always @(posedge clock or negedge reset_n) begin
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      if (!reset_n || clear) begin
        posCount[c] <= 8'h00;
        negCount[c] <= 8'h00;
        clkCount[c] <= 8'h00;
      end else if (prevClk[c] != rxOut[c].recoveredClock) begin
        if (rxOut[c].recoveredClock)
          clkCount[c] <= clkCount[c] + 8'h01;
        if (rxOut[c].recoveredClock == edgeSelect) begin
          posCount[c] <= posCount[c] + 8'(rxOut[c].positiveRailDataOut);
          negCount[c] <= negCount[c] + 8'(rxOut[c].negativeRailDataOut);
        end
      end
      prevClk[c] <= reset_n && rxOut[c].recoveredClock;
    end
  end
endmodule
`default_nettype wire

// ### tb/e1_receive_output_interface_bench.sv
// Bench for the E1 receive output block: APB tasks, line pulse driver.
// Assumes the checker binds itself and the framer model counts marks.
`timescale 1ns/10ps
`default_nettype none
module e1_receive_output_interface_bench
  import e1_rx_out_pkg::*;
;
  logic                        clock = 1'b0;
  logic                        reset_n = 1'b0;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic [ADDR_WIDTH-1:0]       paddr = 8'h00;
  logic [31:0]                 pwdata = 32'h0;
  logic [31:0]                 prdata, rd;
  logic                        pready, pslverr, interrupt, err;
  logic                        receiverOnInput = 1'b1;
  line_in_t [NUM_CHANNELS-1:0] lineIn = '0;
  rx_out_t  [NUM_CHANNELS-1:0] rxOut;
  logic                        clear = 1'b0;
  logic                        edgeSelect = EDGE_RISING;
  logic [NUM_CHANNELS-1:0]     posM, negM;
  logic [3:0]                  ctrl;
  int                          failures = 0;
  int                          checked = 0;
  int                          cycles = 0;
  e1_receive_output_interface i_dut (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receiverOnInput(receiverOnInput),
    .lineIn(lineIn), .rxOut(rxOut), .interrupt(interrupt));
  e1_framer_model i_framer (.clock(clock), .reset_n(reset_n), .clear(clear),
    .edgeSelect(edgeSelect), .rxOut(rxOut));
  always #5 clock = ~clock;
  // Hang guard, well above the few thousand cycles the tests take
  always @(posedge clock) begin
    cycles++;
    if (cycles == 15000) begin
      failures++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // One bit period of about 49 cycles, pulse in its first 4 cycles
  task automatic sendBit(input logic [7:0] p, input logic [7:0] n);
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      lineIn[c].lineInputPositive <= p[c];
      lineIn[c].lineInputNegative <= n[c];
    end
    repeat (4) @(posedge clock);
    for (int c = 0; c < NUM_CHANNELS; c++)
      {lineIn[c].lineInputPositive, lineIn[c].lineInputNegative} <= 2'h0;
    repeat (45) @(posedge clock);
  endtask
  task automatic zeros(input int n);
    repeat (n) sendBit(8'h00, 8'h00);
  endtask
  task automatic clearCounts();
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    apb(1'b0, REG_CONTROL, 32'h0);
    check("control", 32'(CTRL_RESET), rd);
    apb(1'b0, REG_RX_ENABLE, 32'h0);
    check("rx enable", 32'(RX_ENABLE_RESET), rd);
    apb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, REG_STATUS, 32'h0);
    check("status", 32'h0, rd);
    apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    check("write error", 32'h1, 32'(err));
    apb(1'b0, 8'hFC, 32'h0);
    check("read error", 32'h1, 32'(err));
    $display("register test done");
    // Line inputs in high impedance: clocks must keep running
    for (int c = 0; c < NUM_CHANNELS; c++)
      lineIn[c].lineHighZ <= 1'b1;
    clearCounts();
    repeat (2000) @(posedge clock);
    for (int c = 0; c < NUM_CHANNELS; c++)
      check("clock count", 32'h1, 32'(i_framer.clkCount[c] inside {[40:42]}));
    for (int c = 0; c < NUM_CHANNELS; c++)
      lineIn[c].lineHighZ <= 1'b0;
    $display("free run test done");
    // Channel c sees c+1 alternating marks; dual rise, dual fall, single
    for (int m = 0; m < 3; m++) begin
      ctrl = (m == 2) ? 4'h2 : 4'(m);
      edgeSelect <= ctrl[CTRL_EDGE_BIT];
      apb(1'b1, REG_CONTROL, 32'(ctrl));
      zeros(2);
      clearCounts();
      for (int k = 0; k < 8; k++) begin
        for (int c = 0; c < NUM_CHANNELS; c++)
          {posM[c], negM[c]} = {k <= c && k % 2 == 0, k <= c && k % 2 == 1};
        sendBit(posM, negM);
      end
      zeros(4);
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        check("pos count", ctrl[CTRL_SINGLE_BIT] ? 32'(c + 1) : 32'(c / 2 + 1),
              32'(i_framer.posCount[c]));
        if (!ctrl[CTRL_SINGLE_BIT])
          check("neg count", 32'((c + 1) / 2), 32'(i_framer.negCount[c]));
      end
      $display("data test mode %0d done", m);
    end
    // Single rail: channel 1 repeats a polarity, channel 0 stays clean
    for (int k = 0; k < 12; k++) begin
      if (k == 4)
        clearCounts();
      posM = {6'h00, 1'((k % 2 == 1) == (k >= 6)), 1'(k % 2 == 0)};
      sendBit(posM, ~posM & 8'h03);
    end
    check("clean neg", 32'h0, 32'(i_framer.negCount[0]));
    check("violation", 32'h1, 32'(i_framer.negCount[1] != 8'h00));
    // Overflow select: indicator waits for saturation, counter still counts
    apb(1'b1, REG_COUNT_RESET, 32'hFF);
    apb(1'b0, REG_COUNT_BASE + 8'h04, 32'h0);
    check("count reset", 32'h0, rd);
    apb(1'b1, REG_CONTROL, 32'h6);
    clearCounts();
    repeat (3) sendBit(8'h02, 8'h00);
    zeros(2);
    check("overflow neg", 32'h0, 32'(i_framer.negCount[1]));
    apb(1'b0, REG_COUNT_BASE + 8'h04, 32'h0);
    check("count", 32'h1, 32'(rd != 32'h0));
    $display("violation test done");
    // Receivers off: marks must not reach the outputs
    receiverOnInput <= 1'b0;
    edgeSelect <= EDGE_RISING;
    apb(1'b1, REG_CONTROL, 32'h0);
    clearCounts();
    for (int k = 0; k < 8; k++)
      sendBit(k % 2 ? 8'h00 : 8'hFF, k % 2 ? 8'hFF : 8'h00);
    for (int c = 0; c < NUM_CHANNELS; c++)
      check("muted", 32'h0, 32'({i_framer.posCount[c], i_framer.negCount[c]}));
    receiverOnInput <= 1'b1;
    $display("receiver off test done");
    // Loss on channel 2, with its interrupt masked, unmasked and cleared
    lineIn[2].lossCondition <= 1'b1;
    repeat (4) @(negedge clock);
    check("loss flag", 32'h1, 32'(rxOut[2].lossOfSignalFlag));
    apb(1'b0, REG_STATUS, 32'h0);
    check("status", 32'h4, rd);
    apb(1'b0, REG_IRQ_STATUS, 32'h0);
    check("irq status", 32'h4, rd);
    check("masked irq", 32'h0, 32'(interrupt));
    apb(1'b1, REG_IRQ_MASK, 32'h4);
    repeat (2) @(negedge clock);
    check("irq", 32'h1, 32'(interrupt));
    repeat (150) @(negedge clock);
    check("loss held", 32'h1, 32'(rxOut[2].lossOfSignalFlag));
    @(posedge clock);
    lineIn[2].lossCondition <= 1'b0;
    repeat (120) @(negedge clock);
    check("loss cleared", 32'h0, 32'(rxOut[2].lossOfSignalFlag));
    apb(1'b1, REG_IRQ_STATUS, 32'h4);
    repeat (2) @(negedge clock);
    check("irq cleared", 32'h0, 32'(interrupt));
    apb(1'b0, REG_IRQ_STATUS, 32'h0);
    check("irq status", 32'h0, rd);
    $display("loss test done");
    stop_test();
  end
endmodule
`default_nettype wire
